// ==== design/sfcp_defs.svh ====
// constants of the serial flash command port: opcodes, counts, timings
// assumes a 10 MHz core clock; included by the package and the top
`ifndef SFCP_DEFS_SVH
`define SFCP_DEFS_SVH

// array geometry
`define SFCP_ADDR_W        16
`define SFCP_SECTOR_LSB    8
`define SFCP_ERASED        8'hff

// opcodes and confirm / abort codes
`define SFCP_OP_READ       8'hff
`define SFCP_OP_STATUS     8'h9f
`define SFCP_OP_WIPE       8'h20
`define SFCP_OP_CONFIRM    8'hd0
`define SFCP_OP_WRITE      8'h10
`define SFCP_OP_ABORT      8'hff

// byte counts of the command frames
`define SFCP_CMD_BYTES     3'h6
`define SFCP_ABORT_BYTES   3'h5
`define SFCP_READ_LEAD     3'h6
`define SFCP_STATUS_LEAD   3'h1

// self-timed cycle lengths
`define SFCP_CLK_PERIOD_NS 100
`define SFCP_WRITE_TIME_NS 35000
`define SFCP_WIPE_TIME_MS  4
`define SFCP_WRITE_CYCLES  (`SFCP_WRITE_TIME_NS / `SFCP_CLK_PERIOD_NS)
`define SFCP_WIPE_CYCLES   (`SFCP_WIPE_TIME_MS * 1000000 / `SFCP_CLK_PERIOD_NS)
`define SFCP_TIMER_W       16

`endif

// ==== design/sfcp_pkg.sv ====
// types of the serial flash command port
// assumes sfcp_defs.svh is on the include path
package sfcp_pkg;
`include "sfcp_defs.svh"

	// one-hot operation state of the array sequencer
	typedef enum logic [2:0] {
		SFCP_IDLE = 3'b001,
		SFCP_PROG = 3'b010,
		SFCP_WIPE = 3'b100
	} sfcp_op_type;

	// serial clock domain state
	typedef struct packed {
		logic [2:0]              bitcnt;
		logic [2:0]              bytecnt;
		logic [6:0]              shreg;
		logic [7:0]              opcode;
		logic [`SFCP_ADDR_W-1:0] addr;
		logic [7:0]              data;
		logic                    rdy_s1;
		logic                    rdy_s2;
	} sfcp_link_type;

	// falling edge output stage
	typedef struct packed {
		logic so;
		logic oe;
	} sfcp_out_type;

	// core clock domain state
	typedef struct packed {
		sfcp_op_type              op;
		logic [`SFCP_TIMER_W-1:0] timer;
		logic [`SFCP_ADDR_W-1:0]  addr;
		logic [7:0]               data;
		logic                     cs_s1;
		logic                     cs_s2;
		logic                     cs_s3;
		logic                     wp_s1;
		logic                     wp_s2;
		logic                     rst_s1;
		logic                     rst_s2;
		logic                     ready;
	} sfcp_core_type;

endpackage

// ==== design/sfcp_flash_port.sv ====
// serial flash command port: serial front end, sequencer and array
// assumes host drives sck_i, cs_n_i, si_i; pins wp_n_i, reset_n_i async
`include "sfcp_defs.svh"

module sfcp_flash_port #(
	parameter int unsigned WRITE_CYCLES = `SFCP_WRITE_CYCLES,
	parameter int unsigned WIPE_CYCLES  = `SFCP_WIPE_CYCLES
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic sck_i,
	input  wire logic cs_n_i,
	input  wire logic si_i,
	input  wire logic wp_n_i,
	input  wire logic reset_n_i,
	output logic      so_o,
	output logic      so_oe_o
);

	localparam int DEPTH = 1 << `SFCP_ADDR_W;

	sfcp_pkg::sfcp_link_type lk;
	sfcp_pkg::sfcp_link_type next_lk;
	sfcp_pkg::sfcp_out_type  out;
	sfcp_pkg::sfcp_out_type  next_out;
	sfcp_pkg::sfcp_core_type core;
	sfcp_pkg::sfcp_core_type next_core;

	logic                    fresh;
	logic [2:0]              cur_bit;
	logic [2:0]              cur_byte;
	logic [7:0]              in_byte;
	logic                    rd_stream;
	logic [7:0]              obyte;
	logic [7:0]              state_word;
	logic                    cs_rise;
	logic                    full_cmd;
	logic                    abort_cmd;
	logic                    commit;
	logic [7:0]              mem [DEPTH];

	// ---------------- serial clock domain ----------------

	// frame start marker, set while deselected
	always_ff @(posedge sck_i or posedge rst_i or posedge cs_n_i) begin
		if (rst_i || cs_n_i) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	// bit and byte framing, command capture, read address
	always_comb begin
		next_lk = lk;
		cur_bit = fresh ? 3'h0 : lk.bitcnt;
		cur_byte = fresh ? 3'h0 : lk.bytecnt;
		in_byte = {lk.shreg, si_i};
		rd_stream = (lk.opcode == `SFCP_OP_READ) && (cur_byte >= `SFCP_READ_LEAD);
		next_lk.bitcnt = cur_bit + 3'h1;
		next_lk.bytecnt = cur_byte;
		next_lk.shreg = in_byte[6:0];
		next_lk.rdy_s1 = core.ready;
		next_lk.rdy_s2 = lk.rdy_s1;
		// address bytes 2..4, upper bits fall off the top
		if (cur_byte >= 3'h1 && cur_byte <= 3'h3) begin
			next_lk.addr = {lk.addr[`SFCP_ADDR_W-2:0], si_i};
		end
		if (cur_bit == 3'h7) begin
			if (cur_byte != 3'h7) begin
				next_lk.bytecnt = cur_byte + 3'h1;
			end
			if (cur_byte == 3'h0) begin
				next_lk.opcode = in_byte;
			end
			if (cur_byte == 3'h4) begin
				next_lk.data = in_byte;
			end
			// next byte of the stream, wraps naturally
			if (rd_stream) begin
				next_lk.addr = lk.addr + `SFCP_ADDR_W'(1);
			end
		end
		// deselected: clock edges meant for other devices leave the frame alone
		if (cs_n_i) begin
			next_lk = lk;
		end
	end

	// link state, kept across frames for the core to pick up
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// array is quiet during reads since host never reads while busy
	assign obyte = mem[lk.addr];
	assign state_word = {7'h00, lk.rdy_s2};

	// output bit select on the falling edge
	always_comb begin
		next_out = '0;
		if (!fresh && lk.opcode == `SFCP_OP_READ && lk.bytecnt >= `SFCP_READ_LEAD) begin
			next_out.oe = 1'b1;
			next_out.so = obyte[~lk.bitcnt];
		end else if (!fresh && lk.opcode == `SFCP_OP_STATUS
				&& lk.bytecnt >= `SFCP_STATUS_LEAD) begin
			next_out.oe = 1'b1;
			next_out.so = state_word[~lk.bitcnt];
		end
	end

	// output stage floats at once when select rises
	always_ff @(negedge sck_i or posedge rst_i or posedge cs_n_i) begin
		if (rst_i || cs_n_i) begin
			out <= '0;
		end else begin
			out <= next_out;
		end
	end

	assign so_o = out.so;
	assign so_oe_o = out.oe;

	// ---------------- core clock domain ----------------

	// command decode from quiet link state after select rise
	assign cs_rise = core.cs_s2 && !core.cs_s3;
	assign full_cmd = lk.bytecnt >= `SFCP_CMD_BYTES;
	assign abort_cmd = (lk.opcode == `SFCP_OP_WRITE || lk.opcode == `SFCP_OP_WIPE)
		&& lk.bytecnt >= `SFCP_ABORT_BYTES && lk.data == `SFCP_OP_ABORT;
	assign commit = core.op != sfcp_pkg::SFCP_IDLE && core.timer == '0
		&& !(cs_rise && abort_cmd);

	// synchronisers, sequencer and timer
	always_comb begin
		next_core = core;
		next_core.cs_s1 = cs_n_i;
		next_core.cs_s2 = core.cs_s1;
		next_core.cs_s3 = core.cs_s2;
		next_core.wp_s1 = wp_n_i;
		next_core.wp_s2 = core.wp_s1;
		next_core.rst_s1 = reset_n_i;
		next_core.rst_s2 = core.rst_s1;
		case (core.op)
			sfcp_pkg::SFCP_IDLE: begin
				// guard or reset pin low blocks every start
				if (cs_rise && full_cmd && core.wp_s2 && core.rst_s2) begin
					next_core.addr = lk.addr;
					next_core.data = lk.data;
					if (lk.opcode == `SFCP_OP_WRITE) begin
						next_core.op = sfcp_pkg::SFCP_PROG;
						next_core.timer = `SFCP_TIMER_W'(WRITE_CYCLES - 1);
					end else if (lk.opcode == `SFCP_OP_WIPE
							&& lk.data == `SFCP_OP_CONFIRM) begin
						next_core.op = sfcp_pkg::SFCP_WIPE;
						next_core.timer = `SFCP_TIMER_W'(WIPE_CYCLES - 1);
					end
				end
			end
			sfcp_pkg::SFCP_PROG, sfcp_pkg::SFCP_WIPE: begin
				if (cs_rise && abort_cmd) begin
					next_core.op = sfcp_pkg::SFCP_IDLE;
				end else if (core.timer == '0) begin
					next_core.op = sfcp_pkg::SFCP_IDLE;
				end else begin
					next_core.timer = core.timer - `SFCP_TIMER_W'(1);
				end
			end
			default: begin
				next_core.op = sfcp_pkg::SFCP_IDLE;
			end
		endcase
		next_core.ready = next_core.op == sfcp_pkg::SFCP_IDLE;
	end

	// core state register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			core <= '{op: sfcp_pkg::SFCP_IDLE, cs_s1: 1'b1, cs_s2: 1'b1,
				cs_s3: 1'b1, ready: 1'b1, default: '0};
		end else begin
			core <= next_core;
		end
	end

	// array update at the end of a timed cycle, untouched on abort
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `SFCP_ERASED;
			end
		end else if (commit) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (core.op == sfcp_pkg::SFCP_WIPE
						&& i[`SFCP_ADDR_W-1:`SFCP_SECTOR_LSB]
						== core.addr[`SFCP_ADDR_W-1:`SFCP_SECTOR_LSB]) begin
					mem[i] <= `SFCP_ERASED;
				end else if (core.op == sfcp_pkg::SFCP_PROG
						&& i[`SFCP_ADDR_W-1:0] == core.addr) begin
					mem[i] <= core.data;
				end
			end
		end
	end

	// ---------------- checks ----------------

	localparam int WR_LAST = WRITE_CYCLES - 1;
	localparam int WP_LAST = WIPE_CYCLES - 1;

	// output never driven while deselected
	AST_FLOAT_DESELECT: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		core.cs_s2 |-> !so_oe_o
	) else $error("output driven while deselected");

	// read output enabled after the 48th lead bit
	AST_READ_START: assert property (
		@(posedge sck_i) disable iff (rst_i || cs_n_i)
		(!fresh && lk.opcode == `SFCP_OP_READ && lk.bytecnt == 3'h5
			&& lk.bitcnt == 3'h7) |=> ##1 so_oe_o
	) else $error("read output not enabled after lead bits");

	// stream address steps by one per byte
	AST_READ_STEP: assert property (
		@(posedge sck_i) disable iff (rst_i || cs_n_i)
		(!fresh && lk.opcode == `SFCP_OP_READ && lk.bytecnt >= 3'h6
			&& lk.bitcnt == 3'h7 && lk.addr != '1)
		|=> lk.addr == $past(lk.addr) + `SFCP_ADDR_W'(1)
	) else $error("read address did not step");

	// stream address wraps to zero
	AST_READ_WRAP: assert property (
		@(posedge sck_i) disable iff (rst_i || cs_n_i)
		(!fresh && lk.opcode == `SFCP_OP_READ && lk.bytecnt >= 3'h6
			&& lk.bitcnt == 3'h7 && lk.addr == '1) |=> lk.addr == '0
	) else $error("read address did not wrap");

	// last status bit shows the ready flag
	AST_STATUS_READY: assert property (
		@(posedge sck_i) disable iff (rst_i || cs_n_i)
		(!fresh && lk.opcode == `SFCP_OP_STATUS && lk.bytecnt >= 3'h1
			&& lk.bitcnt == 3'h7) |-> so_oe_o && so_o == lk.rdy_s2
	) else $error("status bit 0 is not the ready flag");

	// write cycle loads its full length
	AST_WRITE_LEN: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		($past(core.op) == sfcp_pkg::SFCP_IDLE && core.op == sfcp_pkg::SFCP_PROG)
		|-> int'(core.timer) == WR_LAST && !core.ready
	) else $error("write cycle length wrong");

	// wipe cycle loads its full length
	AST_WIPE_LEN: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		($past(core.op) == sfcp_pkg::SFCP_IDLE && core.op == sfcp_pkg::SFCP_WIPE)
		|-> int'(core.timer) == WP_LAST
	) else $error("wipe cycle length wrong");

	// busy ends when the timer runs out
	AST_CYCLE_END: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(core.op != sfcp_pkg::SFCP_IDLE && core.timer == '0)
		|=> core.op == sfcp_pkg::SFCP_IDLE && core.ready
	) else $error("timed cycle did not end");

	// guard pin low keeps the sequencer idle
	AST_GUARD_BLOCKS: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(core.op == sfcp_pkg::SFCP_IDLE && !core.wp_s2)
		|=> core.op == sfcp_pkg::SFCP_IDLE
	) else $error("start while write guard low");

	// short frames start nothing
	AST_SHORT_DROP: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(core.op == sfcp_pkg::SFCP_IDLE && cs_rise && lk.bytecnt < 3'h6)
		|=> core.op == sfcp_pkg::SFCP_IDLE
	) else $error("short frame started a cycle");

	// abort code stops a running cycle
	AST_ABORT_STOPS: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(core.op != sfcp_pkg::SFCP_IDLE && cs_rise && abort_cmd)
		|=> core.op == sfcp_pkg::SFCP_IDLE ##1 core.ready
	) else $error("abort ignored");

	// clock edges while deselected leave the frame state alone
	AST_DESELECT_HOLD: assert property (
		@(posedge sck_i) disable iff (rst_i)
		cs_n_i |=> lk == $past(lk)
	) else $error("link state moved while deselected");

	// wipe without the confirm code starts nothing
	AST_WIPE_CONFIRM: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		(core.op == sfcp_pkg::SFCP_IDLE && cs_rise && lk.opcode == `SFCP_OP_WIPE
			&& lk.data != `SFCP_OP_CONFIRM) |=> core.op == sfcp_pkg::SFCP_IDLE
	) else $error("wipe started without confirm code");

	COV_READ_WRAP: cover property (
		@(posedge sck_i) disable iff (rst_i || cs_n_i)
		!fresh && lk.opcode == `SFCP_OP_READ && lk.bytecnt >= 3'h6 && lk.addr == '1
	);

	COV_WRITE_DONE: cover property (
		@(posedge mclk_i) disable iff (rst_i)
		core.op == sfcp_pkg::SFCP_PROG && commit
	);

	COV_WIPE_DONE: cover property (
		@(posedge mclk_i) disable iff (rst_i)
		core.op == sfcp_pkg::SFCP_WIPE && commit
	);

	COV_ABORT: cover property (
		@(posedge mclk_i) disable iff (rst_i)
		core.op != sfcp_pkg::SFCP_IDLE && cs_rise && abort_cmd
	);

endmodule // sfcp_flash_port

// ==== bench/sfcp_host_model.sv ====
// host side serial controller model: drives select, serial clock, data in
// assumes a frame is started only while the flash port is not mid-frame
module sfcp_host_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic mode3 = 1'b0; // set by the bench: clock idles high in mode 3

	// idle: deselected, clock low, data line parked
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// one serial clock period carrying one input bit, taken at the rise
	task automatic pulse(input logic b);
		if (mode3) begin
			#16 sck_o = 1'b0;
			si_o = b;
			#16 sck_o = 1'b1;
		end else begin
			si_o = b;
			#16 sck_o = 1'b1;
			#16 sck_o = 1'b0;
		end
	endtask

	// one frame: bytes msb first, then nrd bytes of read clocks
	task automatic frame(input logic [7:0] q[$], input int nrd);
		sck_o = mode3; // idle level set while still deselected
		#20 cs_n_o = 1'b0;
		#20;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				pulse(q[i][b]);
			end
		end
		for (int b = 0; b < 8 * nrd; b++) begin
			pulse(~si_o);
		end
		#20 cs_n_o = 1'b1;
		si_o = ~si_o; // released line shows no stale bit
		#400; // select stays high over four core clocks
	endtask
endmodule // sfcp_host_model

// ==== bench/test_serial_flash_command_port.sv ====
// testbench of the serial flash command port
// assumes sfcp_flash_port and sfcp_host_model are compiled first
module test_serial_flash_command_port;
	timeunit 1ns;
	timeprecision 1ps;

	logic       mclk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       wp_n_i = 1'b1;
	logic       reset_n_i = 1'b1;
	wire        sck;
	wire        cs_n;
	wire        si;
	wire        so;
	wire        so_oe;
	int         n_mismatch = 0;
	int         checks_done = 0;
	int         cycles = 0;
	int         nbit = 0;
	int         seed = 32'h00027523;
	logic [7:0] exp_q[$];
	logic [7:0] shift;
	logic [7:0] d[4];

	always #50 mclk_i = ~mclk_i;

	sfcp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));

	sfcp_flash_port #(.WRITE_CYCLES(40), .WIPE_CYCLES(50)) dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
		.wp_n_i(wp_n_i), .reset_n_i(reset_n_i), .so_o(so), .so_oe_o(so_oe)
	);

	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk1(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// gather driven output bits at each serial clock rise
	always @(posedge sck) begin
		if (!cs_n && so_oe === 1'b1) begin
			shift = {shift[6:0], so};
			nbit++;
			if (nbit == 8) begin
				nbit = 0;
				chk8("output byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, shift);
			end
		end
	end

	always @(posedge cs_n) nbit = 0;

	// cut a hang short
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask

	task automatic status(input logic [7:0] e);
		exp_q.push_back(e);
		host.frame('{8'h9f}, 1);
		chk1("output enable after select", 1'b0, so_oe);
	endtask

	task automatic read(input logic [15:0] a, input logic [7:0] e[$]);
		foreach (e[i]) exp_q.push_back(e[i]);
		host.frame('{8'hff, 8'h00, a[15:8], a[7:0], 8'h00, 8'h00}, e.size());
		chk1("output enable after select", 1'b0, so_oe);
		chk8("unread bytes", 8'h00, 8'(exp_q.size()));
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] v);
		host.frame('{8'h10, 8'h00, a[15:8], a[7:0], v, 8'h00}, 0);
	endtask

	task automatic endtest(input string name);
		$display("test %s done", name);
	endtask

	// main sequence
	initial begin
		foreach (d[i]) d[i] = 8'($random(seed));
		repeat (12) @(posedge mclk_i);
		#2 rst_i = 1'b0;
		idle(3);
		status(8'h01);
		endtest("status idle");
		prog(16'hfffe, d[0]);
		status(8'h00);
		idle(60);
		status(8'h01);
		prog(16'hffff, d[1]);
		idle(60);
		read(16'hfffe, '{d[0], d[1], 8'hff});
		endtest("program and wrapping read");
		prog(16'hfeff, d[2]);
		idle(60);
		host.frame('{8'h20, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00}, 0);
		status(8'h01);
		host.frame('{8'h20, 8'h00, 8'hff, 8'h00, 8'hd0, 8'h00}, 0);
		status(8'h00);
		idle(90);
		read(16'hfeff, '{d[2], 8'hff, 8'hff});
		read(16'hfffe, '{8'hff, 8'hff});
		endtest("sector wipe");
		prog(16'h1234, d[3]);
		host.frame('{8'h10, 8'h00, 8'h12, 8'h34, 8'hff}, 0);
		idle(4);
		status(8'h01);
		read(16'h1234, '{8'hff});
		endtest("abort");
		host.mode3 = 1'b1;
		host.frame('{8'h10, 8'h00, 8'h00, 8'h20, d[3]}, 0);
		idle(1);
		wp_n_i = 1'b0;
		prog(16'h0021, d[3]);
		idle(10);
		status(8'h01);
		idle(1);
		wp_n_i = 1'b1;
		reset_n_i = 1'b0;
		prog(16'h0022, d[3]);
		idle(10);
		status(8'h01);
		idle(1);
		reset_n_i = 1'b1;
		idle(60);
		read(16'h0020, '{8'hff, 8'hff, 8'hff});
		endtest("guards and short frame in mode 3");
		conclude();
	end
endmodule // test_serial_flash_command_port
